// ### uepsf_regs.svh
// Register offsets, field positions and reset values of the endpoint status flags block.
// Assumes byte addressing on a 32-bit APB with one aligned word per register.
`ifndef UEPSF_REGS_SVH
`define UEPSF_REGS_SVH
`define UEPSF_OFF_SELECTOR 12'h000
`define UEPSF_OFF_TX_STATUS 12'h004
`define UEPSF_OFF_RX_STATUS 12'h008
`define UEPSF_OFF_CONTROL 12'h00C
`define UEPSF_TX_TOGGLE_BIT 7
`define UEPSF_TX_VOID_BIT 2
`define UEPSF_TX_ERR_BIT 1
`define UEPSF_TX_ACK_BIT 0
`define UEPSF_RX_TOGGLE_BIT 7
`define UEPSF_RX_SETUP_BIT 6
`define UEPSF_RX_SETUP_OVERWRITE_START_FLAG_BIT 5
`define UEPSF_RX_SETUP_OVERWRITE_END_FLAG_BIT 4
`define UEPSF_CTL_RX_STALL_BIT 0
`define UEPSF_CTL_TX_STALL_BIT 1
`define UEPSF_CTL_CONTROL_EP_BIT 2
`define UEPSF_CTL_RESET 8'h04
`define UEPSF_CTL_RESET_OTHER 8'h00
`endif

// ### uepsf_pkg.sv
// Types shared by the endpoint status flags block.
// Assumes nothing beyond a SystemVerilog tool.
package uepsf_pkg;
	typedef enum logic [1:0] {
		UEPSF_HS_NONE = 2'b00,
		UEPSF_HS_ACK = 2'b01,
		UEPSF_HS_NAK = 2'b10,
		UEPSF_HS_STALL = 2'b11
	} uepsf_handshake_e;
	typedef logic [1:0] uepsf_ep_t;
endpackage

// ### uepsf_tx_flags.sv
// Transmit status flags of one endpoint: toggle, void, error and acked.
// Assumes link event pulses last one cycle and belong to this endpoint.
`timescale 1ns/1ps
`include "uepsf_regs.svh"
module uepsf_tx_flags (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic setup_tok,
	input wire logic in_end,
	input wire logic in_void,
	input wire logic tx_end,
	input wire logic tx_ok,
	input wire logic sw_clr_toggle,
	output logic tx_data_toggle,
	output logic tx_void_flag,
	output logic tx_error_flag,
	output logic tx_acked_flag,
	output logic tx_done_set
);
	// Toggle: hardware flips win over a software clear in the same cycle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx_data_toggle <= 1'b0;
		end else if (setup_tok) begin
			tx_data_toggle <= ~tx_data_toggle;
		end else if (tx_end && tx_ok) begin
			tx_data_toggle <= ~tx_data_toggle;
		end else if (sw_clr_toggle) begin
			tx_data_toggle <= 1'b0;
		end
	end

	// Void is refreshed at every IN transaction end and nothing else
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx_void_flag <= 1'b0;
		end else if (in_end) begin
			tx_void_flag <= in_void;
		end
	end

	// Error and acked move together so they stay mutually exclusive
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx_error_flag <= 1'b0;
			tx_acked_flag <= 1'b0;
		end else if (tx_end) begin
			tx_error_flag <= ~tx_ok;
			tx_acked_flag <= tx_ok;
		end
	end

	// Done pulse follows data end only, never the void path
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx_done_set <= 1'b0;
		end else begin
			tx_done_set <= tx_end;
		end
	end
endmodule

// ### uepsf_rx_flags.sv
// Receive setup tracking of one endpoint: toggle, setup flag, overwrite lock.
// Assumes link event pulses last one cycle and belong to this endpoint.
`timescale 1ns/1ps
`include "uepsf_regs.svh"
module uepsf_rx_flags (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic control_ep,
	input wire logic setup_tok,
	input wire logic setup_hs_end,
	input wire logic out_ack_end,
	input wire logic sw_clr_toggle,
	input wire logic sw_clr_setup,
	input wire logic sw_clr_setup_overwrite_end_flag,
	output logic rx_data_toggle,
	output logic setup_received_flag,
	output logic setup_overwrite_start_flag,
	output logic setup_overwrite_end_flag
);
	// Toggle: setup forces one, ack flips, software clear loses to hardware
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rx_data_toggle <= 1'b0;
		end else if (setup_tok) begin
			rx_data_toggle <= 1'b1;
		end else if (out_ack_end) begin
			rx_data_toggle <= ~rx_data_toggle;
		end else if (sw_clr_toggle) begin
			rx_data_toggle <= 1'b0;
		end
	end

	// Setup flag: set beats clear
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			setup_received_flag <= 1'b0;
		end else if (setup_tok) begin
			setup_received_flag <= 1'b1;
		end else if (sw_clr_setup) begin
			setup_received_flag <= 1'b0;
		end
	end

	// Start overwrite lives from setup token to handshake end, control only
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			setup_overwrite_start_flag <= 1'b0;
		end else if (setup_tok && control_ep) begin
			setup_overwrite_start_flag <= 1'b1;
		end else if (setup_hs_end) begin
			setup_overwrite_start_flag <= 1'b0;
		end
	end

	// End overwrite set at handshake end; firmware clear unlocks the FIFO
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			setup_overwrite_end_flag <= 1'b0;
		end else if (setup_hs_end && control_ep) begin
			setup_overwrite_end_flag <= 1'b1;
		end else if (sw_clr_setup_overwrite_end_flag) begin
			setup_overwrite_end_flag <= 1'b0;
		end
	end
endmodule

// ### uepsf_top.sv
// Endpoint status flags of a USB function: per-endpoint flags behind APB.
// Assumes the link engine gives one-cycle event pulses tagged with an endpoint.
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
`include "uepsf_regs.svh"
module uepsf_top #(
	parameter int NUM_EP = 4
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [1:0] link_ep,
	input wire logic link_setup_tok,
	input wire logic link_in_tok,
	input wire logic link_out_tok,
	input wire logic link_in_end,
	input wire logic link_in_void,
	input wire logic link_tx_end,
	input wire logic link_tx_ok,
	input wire logic link_setup_hs_end,
	input wire logic link_out_ack_end,
	input wire logic link_tx_ready,
	input wire logic link_rx_ready,
	output uepsf_pkg::uepsf_handshake_e token_answer,
	output logic token_answer_valid,
	output logic tx_data_pid_toggle,
	output logic [NUM_EP-1:0] tx_done_interrupt,
	output logic [NUM_EP-1:0] rx_fifo_lock,
	output logic [NUM_EP-1:0] rx_fifo_reset
);
	logic [1:0] endpoint_selector;
	logic [7:0] ep_ctl [NUM_EP];
	logic [NUM_EP-1:0] tx_tog, tx_void, tx_err, tx_ack, tx_done_set;
	logic [NUM_EP-1:0] rx_tog, rx_setup, rx_setup_overwrite_start_flag, rx_setup_overwrite_end_flag;
	logic [NUM_EP-1:0] clr_tx_tog, clr_rx_tog, clr_setup, clr_setup_overwrite_end_flag;
	logic wr_access, rd_access;
	logic [31:0] next_prdata;
	logic [7:0] tx_stat_sel, rx_stat_sel;
	uepsf_pkg::uepsf_handshake_e next_answer;

	assign wr_access = psel && penable && pwrite && pready;
	assign rd_access = psel && penable && !pwrite;

	// Per-endpoint flag banks and software clear strobes
	for (genvar i = 0; i < NUM_EP; i++) begin : g_ep
		logic hit;
		logic tx_wr, rx_wr;
		assign hit = (endpoint_selector == i[1:0]);
		assign tx_wr = wr_access && hit && (paddr == `UEPSF_OFF_TX_STATUS);
		assign rx_wr = wr_access && hit && (paddr == `UEPSF_OFF_RX_STATUS);
		// Only writing zero to a clearable bit clears it; other bits ignore writes
		assign clr_tx_tog[i] = tx_wr && !pwdata[`UEPSF_TX_TOGGLE_BIT];
		assign clr_rx_tog[i] = rx_wr && !pwdata[`UEPSF_RX_TOGGLE_BIT];
		assign clr_setup[i] = rx_wr && !pwdata[`UEPSF_RX_SETUP_BIT];
		assign clr_setup_overwrite_end_flag[i] = rx_wr && !pwdata[`UEPSF_RX_SETUP_OVERWRITE_END_FLAG_BIT];

		uepsf_tx_flags u_tx (
			.clk(clk),
			.sys_rst(sys_rst),
			.setup_tok(link_setup_tok && link_ep == i[1:0]),
			.in_end(link_in_end && link_ep == i[1:0]),
			.in_void(link_in_void),
			.tx_end(link_tx_end && link_ep == i[1:0]),
			.tx_ok(link_tx_ok),
			.sw_clr_toggle(clr_tx_tog[i]),
			.tx_data_toggle(tx_tog[i]),
			.tx_void_flag(tx_void[i]),
			.tx_error_flag(tx_err[i]),
			.tx_acked_flag(tx_ack[i]),
			.tx_done_set(tx_done_set[i])
		);

		uepsf_rx_flags u_rx (
			.clk(clk),
			.sys_rst(sys_rst),
			.control_ep(ep_ctl[i][`UEPSF_CTL_CONTROL_EP_BIT]),
			.setup_tok(link_setup_tok && link_ep == i[1:0]),
			.setup_hs_end(link_setup_hs_end && link_ep == i[1:0]),
			.out_ack_end(link_out_ack_end && link_ep == i[1:0]),
			.sw_clr_toggle(clr_rx_tog[i]),
			.sw_clr_setup(clr_setup[i]),
			.sw_clr_setup_overwrite_end_flag(clr_setup_overwrite_end_flag[i]),
			.rx_data_toggle(rx_tog[i]),
			.setup_received_flag(rx_setup[i]),
			.setup_overwrite_start_flag(rx_setup_overwrite_start_flag[i]),
			.setup_overwrite_end_flag(rx_setup_overwrite_end_flag[i])
		);

		// Control register; endpoint 0 starts as a control endpoint.
		// A setup token clears both stalls so the host can recover the endpoint.
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				ep_ctl[i] <= (i == 0) ? `UEPSF_CTL_RESET : `UEPSF_CTL_RESET_OTHER;
			end else if (link_setup_tok && link_ep == i[1:0]) begin
				ep_ctl[i][`UEPSF_CTL_RX_STALL_BIT] <= 1'b0;
				ep_ctl[i][`UEPSF_CTL_TX_STALL_BIT] <= 1'b0;
			end else if (wr_access && hit && paddr == `UEPSF_OFF_CONTROL) begin
				ep_ctl[i] <= {5'b0_0000, pwdata[2:0]};
			end
		end

		// Done is sticky until the same register is written with bit 7 set
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				tx_done_interrupt[i] <= 1'b0;
			end else if (tx_done_set[i]) begin
				tx_done_interrupt[i] <= 1'b1;
			end else if (wr_access && hit && paddr == `UEPSF_OFF_CONTROL && pwdata[7]) begin
				tx_done_interrupt[i] <= 1'b0;
			end
		end

		// FIFO lock: reset while start is up, held locked until end is cleared
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				rx_fifo_lock[i] <= 1'b0;
				rx_fifo_reset[i] <= 1'b0;
			end else begin
				rx_fifo_reset[i] <= rx_setup_overwrite_start_flag[i];
				rx_fifo_lock[i] <= rx_setup_overwrite_start_flag[i] || rx_setup_overwrite_end_flag[i];
			end
		end
	end

	// Endpoint selector: upper bits ignored and read as zero
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			endpoint_selector <= 2'b00;
		end else if (wr_access && paddr == `UEPSF_OFF_SELECTOR) begin
			endpoint_selector <= pwdata[1:0];
		end
	end

	// Status images of the selected endpoint, reserved bits zero
	always_comb begin
		tx_stat_sel = 8'h00;
		rx_stat_sel = 8'h00;
		tx_stat_sel[`UEPSF_TX_TOGGLE_BIT] = tx_tog[endpoint_selector];
		tx_stat_sel[`UEPSF_TX_VOID_BIT] = tx_void[endpoint_selector];
		tx_stat_sel[`UEPSF_TX_ERR_BIT] = tx_err[endpoint_selector];
		tx_stat_sel[`UEPSF_TX_ACK_BIT] = tx_ack[endpoint_selector];
		rx_stat_sel[`UEPSF_RX_TOGGLE_BIT] = rx_tog[endpoint_selector];
		rx_stat_sel[`UEPSF_RX_SETUP_BIT] = rx_setup[endpoint_selector];
		rx_stat_sel[`UEPSF_RX_SETUP_OVERWRITE_START_FLAG_BIT] = rx_setup_overwrite_start_flag[endpoint_selector];
		rx_stat_sel[`UEPSF_RX_SETUP_OVERWRITE_END_FLAG_BIT] = rx_setup_overwrite_end_flag[endpoint_selector];
	end

	// Read mux; unmapped addresses read zero and flag an error
	always_comb begin
		next_prdata = 32'h0000_0000;
		case (paddr)
			`UEPSF_OFF_SELECTOR: next_prdata = {30'h0000_0000, endpoint_selector};
			`UEPSF_OFF_TX_STATUS: next_prdata = {24'h00_0000, tx_stat_sel};
			`UEPSF_OFF_RX_STATUS: next_prdata = {24'h00_0000, rx_stat_sel};
			`UEPSF_OFF_CONTROL: next_prdata = {24'h00_0000, tx_done_interrupt[endpoint_selector],
				ep_ctl[endpoint_selector][6:0]};
			default: next_prdata = 32'h0000_0000;
		endcase
	end

	// APB slave: one wait state, so pready rises in the second access cycle.
	// Registering the answer keeps every bus output straight from a flip-flop.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (psel && penable && !pready) begin
			pready <= 1'b1;
			prdata <= rd_access ? next_prdata : 32'h0000_0000;
			pslverr <= !(paddr == `UEPSF_OFF_SELECTOR || paddr == `UEPSF_OFF_TX_STATUS ||
				paddr == `UEPSF_OFF_RX_STATUS || paddr == `UEPSF_OFF_CONTROL);
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// Token answer: pending setup NAKs before stall is considered
	always_comb begin
		next_answer = uepsf_pkg::UEPSF_HS_NONE;
		if (link_in_tok) begin
			if (rx_setup[link_ep]) begin
				next_answer = uepsf_pkg::UEPSF_HS_NAK;
			end else if (ep_ctl[link_ep][`UEPSF_CTL_TX_STALL_BIT]) begin
				next_answer = uepsf_pkg::UEPSF_HS_STALL;
			end else if (!link_tx_ready) begin
				next_answer = uepsf_pkg::UEPSF_HS_NAK;
			end else begin
				next_answer = uepsf_pkg::UEPSF_HS_NONE;
			end
		end else if (link_out_tok) begin
			if (rx_setup[link_ep]) begin
				next_answer = uepsf_pkg::UEPSF_HS_NAK;
			end else if (ep_ctl[link_ep][`UEPSF_CTL_RX_STALL_BIT]) begin
				next_answer = uepsf_pkg::UEPSF_HS_STALL;
			end else if (!link_rx_ready || rx_setup_overwrite_start_flag[link_ep] || rx_setup_overwrite_end_flag[link_ep]) begin
				next_answer = uepsf_pkg::UEPSF_HS_NAK;
			end else begin
				next_answer = uepsf_pkg::UEPSF_HS_ACK;
			end
		end
	end

	// Answer and data toggle registered one cycle after the token
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			token_answer <= uepsf_pkg::UEPSF_HS_NONE;
			token_answer_valid <= 1'b0;
			tx_data_pid_toggle <= 1'b0;
		end else begin
			token_answer <= next_answer;
			token_answer_valid <= link_in_tok || link_out_tok;
			tx_data_pid_toggle <= tx_tog[link_ep];
		end
	end
endmodule

// ### uepsf_top_asserts.sv
// Checker for the endpoint status flags block, bound to its top module.
// Assumes endpoint 0 stays a control endpoint and endpoint 3 never becomes one.
`timescale 1ns/1ps
module uepsf_top_asserts #(
	parameter int NUM_EP = 4
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [1:0] link_ep,
	input wire logic link_setup_tok,
	input wire logic link_in_tok,
	input wire logic link_out_tok,
	input wire logic link_in_end,
	input wire logic link_tx_end,
	input wire logic link_tx_ok,
	input wire uepsf_pkg::uepsf_handshake_e token_answer,
	input wire logic token_answer_valid,
	input wire logic tx_data_pid_toggle,
	input wire logic [NUM_EP-1:0] tx_done_interrupt,
	input wire logic [NUM_EP-1:0] rx_fifo_lock,
	input wire logic [NUM_EP-1:0] rx_fifo_reset
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// A flip shows on the PID output two cycles on, so the endpoint must hold still meanwhile
	sequence flip_s;
		(link_setup_tok && link_ep == 2'h0 || link_tx_end && link_tx_ok) && !psel ##1 $stable(link_ep);
	endsequence
	// Setup arrival, then a token with no software access that could clear the flag
	sequence setup_token_s;
		link_setup_tok ##1 !psel ##1 (link_in_tok || link_out_tok) && !psel;
	endsequence
	apb_wait_a: assert property (psel && penable && !pready |=> pready) else $error("APB answer missing");
	pready_pulse_a: assert property (pready |=> !pready) else $error("pready held too long");
	slverr_qual_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
	token_pulse_a: assert property (link_in_tok || link_out_tok |=> token_answer_valid) else $error("no answer");
	tx_toggle_a: assert property (flip_s |=> tx_data_pid_toggle != $past(tx_data_pid_toggle))
		else $error("toggle did not flip");
	setup_nak_a: assert property (setup_token_s |=> token_answer == uepsf_pkg::UEPSF_HS_NAK)
		else $error("token not NAKed");
	done_raise_a: assert property (link_tx_end |-> ##2 tx_done_interrupt[$past(link_ep, 2)])
		else $error("done not raised");
	// Done would move two edges after the event, through the registered done pulse
	void_done_a: assert property (link_in_end && !link_tx_end && !(psel && penable) |-> ##2 $stable(tx_done_interrupt))
		else $error("void changed done");
	fifo_lock_a: assert property (link_setup_tok && link_ep == 2'h0 |-> ##2 rx_fifo_lock[0] && rx_fifo_reset[0])
		else $error("fifo not locked");
	ctl_only_a: assert property (link_setup_tok && link_ep == 2'h3 |-> ##2 !rx_fifo_lock[3])
		else $error("lock on non-control endpoint");
endmodule
bind uepsf_top uepsf_top_asserts #(.NUM_EP(NUM_EP)) u_asserts (.clk, .sys_rst, .psel, .penable, .pready, .pslverr,
	.link_ep, .link_setup_tok, .link_in_tok, .link_out_tok, .link_in_end, .link_tx_end, .link_tx_ok, .token_answer,
	.token_answer_valid, .tx_data_pid_toggle, .tx_done_interrupt, .rx_fifo_lock, .rx_fifo_reset);

// ### uepsf_host_model.sv
// Link-side partner: host traffic seen as one-cycle event pulses with their qualifiers.
// Assumes the bench calls send and reads token answers at the device.
`timescale 1ns/1ps
module uepsf_host_model (
	input wire logic clk,
	output logic [1:0] link_ep,
	output logic link_setup_tok,
	output logic link_in_tok,
	output logic link_out_tok,
	output logic link_in_end,
	output logic link_in_void,
	output logic link_tx_end,
	output logic link_tx_ok,
	output logic link_setup_hs_end,
	output logic link_out_ack_end,
	output logic link_tx_ready,
	output logic link_rx_ready
);
	logic [6:0] ev = 7'h00;
	// One bit per event kind keeps every pulse exactly one cycle wide
	assign {link_out_ack_end, link_setup_hs_end, link_tx_end, link_in_end, link_out_tok, link_in_tok, link_setup_tok} = ev;
	// FIFOs always ready; qualifiers start at a defined level
	initial begin
		link_ep = 2'h0;
		link_in_void = 1'b1;
		link_tx_ok = 1'b1;
		link_tx_ready = 1'b1;
		link_rx_ready = 1'b1;
	end
	// Qualifiers flip after the pulse so a stale value cannot pass for a fresh one
	task automatic send(input int k, input logic [1:0] ep, input logic q);
		@(posedge clk);
		ev <= 7'h01 << k;
		link_ep <= ep;
		link_in_void <= q;
		link_tx_ok <= q;
		@(posedge clk);
		ev <= 7'h00;
		link_in_void <= ~q;
		link_tx_ok <= ~q;
	endtask
endmodule

// ### uepsf_top_tb.sv
// Self-checking bench for the endpoint status flags block.
// Assumes the host model drives the link side and the register map of the header.
`timescale 1ns/1ps
`include "uepsf_regs.svh"
module uepsf_top_tb;
	localparam int E_SETUP = 0, E_IN = 1, E_OUT = 2, E_IN_END = 3, E_TX_END = 4, E_HS_END = 5, E_OUT_ACK = 6;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, last_err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, r;
	logic pready, pslverr, link_setup_tok, link_in_tok, link_out_tok, link_in_end, link_in_void, link_tx_end;
	logic link_tx_ok, link_setup_hs_end, link_out_ack_end, link_tx_ready, link_rx_ready;
	logic token_answer_valid, tx_data_pid_toggle;
	logic [1:0] link_ep;
	logic [3:0] tx_done_interrupt, rx_fifo_lock, rx_fifo_reset;
	uepsf_pkg::uepsf_handshake_e token_answer;
	int error_cnt = 0, total_checks = 0, cycles = 0;
	uepsf_top u_dut (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .link_ep,
		.link_setup_tok, .link_in_tok, .link_out_tok, .link_in_end, .link_in_void, .link_tx_end, .link_tx_ok,
		.link_setup_hs_end, .link_out_ack_end, .link_tx_ready, .link_rx_ready, .token_answer, .token_answer_valid,
		.tx_data_pid_toggle, .tx_done_interrupt, .rx_fifo_lock, .rx_fifo_reset);
	uepsf_host_model u_host (.clk, .link_ep, .link_setup_tok, .link_in_tok, .link_out_tok, .link_in_end, .link_in_void,
		.link_tx_end, .link_tx_ok, .link_setup_hs_end, .link_out_ack_end, .link_tx_ready, .link_rx_ready);
	// 20 MHz clock
	initial begin
		forever #25 clk = ~clk;
	end
	// Hang guard: the run needs under 150 cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			error_cnt++;
			end_of_test();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask
	// Holds the request until pready is seen high at an edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge clk);
		penable <= 1'b1;
		// Only the hang guard ends this wait if pready never rises
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		chk({31'h0000_0000, pready}, 32'h0000_0001, "apb answer");
		r = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] e, input string msg);
		apb(1'b0, a, 8'h00);
		chk(r, {24'h00_0000, e}, msg);
	endtask
	// One token, then its registered answer looked at while it stands
	task automatic tok(input int k, input logic [1:0] ep, input uepsf_pkg::uepsf_handshake_e e, input string msg);
		u_host.send(k, ep, 1'b0);
		#1;
		chk({29'h0000_0000, token_answer_valid, token_answer}, {29'h0000_0000, 1'b1, e}, msg);
	endtask
	task automatic t_reset();
		rd(`UEPSF_OFF_TX_STATUS, 8'h00, "tx status reset");
		rd(`UEPSF_OFF_RX_STATUS, 8'h00, "rx status reset");
		rd(`UEPSF_OFF_CONTROL, `UEPSF_CTL_RESET, "control reset");
		rd(12'h010, 8'h00, "unmapped read");
		chk({31'h0000_0000, last_err}, 32'h0000_0001, "unmapped error");
		$display("reset test finished");
	endtask
	task automatic t_tx();
		apb(1'b1, `UEPSF_OFF_SELECTOR, 8'h01);
		u_host.send(E_TX_END, 2'h1, 1'b1);
		rd(`UEPSF_OFF_TX_STATUS, 8'h81, "acked");
		rd(`UEPSF_OFF_CONTROL, 8'h80, "done raised");
		u_host.send(E_TX_END, 2'h1, 1'b0);
		rd(`UEPSF_OFF_TX_STATUS, 8'h82, "no handshake");
		apb(1'b1, `UEPSF_OFF_TX_STATUS, 8'h00);
		rd(`UEPSF_OFF_TX_STATUS, 8'h02, "toggle cleared only");
		apb(1'b1, `UEPSF_OFF_CONTROL, 8'h80);
		u_host.send(E_IN_END, 2'h1, 1'b1);
		rd(`UEPSF_OFF_TX_STATUS, 8'h06, "void set");
		rd(`UEPSF_OFF_CONTROL, 8'h00, "void leaves done");
		u_host.send(E_IN_END, 2'h1, 1'b0);
		rd(`UEPSF_OFF_TX_STATUS, 8'h02, "void refreshed");
		$display("transmit test finished");
	endtask
	task automatic t_setup();
		apb(1'b1, `UEPSF_OFF_SELECTOR, 8'h00);
		apb(1'b1, `UEPSF_OFF_CONTROL, 8'h07);
		u_host.send(E_SETUP, 2'h0, 1'b0);
		for (int k = E_IN; k <= E_OUT; k++) begin
			tok(k, 2'h0, uepsf_pkg::UEPSF_HS_NAK, "nak");
		end
		// Setup cleared the stalls; set them again while the setup is still pending
		apb(1'b1, `UEPSF_OFF_CONTROL, 8'h07);
		tok(E_IN, 2'h0, uepsf_pkg::UEPSF_HS_NAK, "nak despite tx stall");
		tok(E_OUT, 2'h0, uepsf_pkg::UEPSF_HS_NAK, "nak despite rx stall");
		rd(`UEPSF_OFF_RX_STATUS, 8'hE0, "setup arrival");
		rd(`UEPSF_OFF_TX_STATUS, 8'h80, "tx toggle on setup");
		chk({31'h0000_0000, tx_data_pid_toggle}, 32'h0000_0001, "pid toggle");
		chk({31'h0000_0000, rx_fifo_lock[0]}, 32'h0000_0001, "fifo locked");
		chk({31'h0000_0000, rx_fifo_reset[0]}, 32'h0000_0001, "fifo reset");
		u_host.send(E_HS_END, 2'h0, 1'b0);
		rd(`UEPSF_OFF_RX_STATUS, 8'hD0, "handshake end");
		apb(1'b1, `UEPSF_OFF_RX_STATUS, 8'h80);
		rd(`UEPSF_OFF_RX_STATUS, 8'h80, "firmware clears");
		chk({31'h0000_0000, rx_fifo_lock[0]}, 32'h0000_0000, "fifo unlocked");
		chk({31'h0000_0000, rx_fifo_reset[0]}, 32'h0000_0000, "fifo reset released");
		// With the setup done, stalls answer again, then plain ACK and data
		tok(E_OUT, 2'h0, uepsf_pkg::UEPSF_HS_STALL, "rx stall");
		tok(E_IN, 2'h0, uepsf_pkg::UEPSF_HS_STALL, "tx stall");
		apb(1'b1, `UEPSF_OFF_CONTROL, 8'h04);
		tok(E_OUT, 2'h0, uepsf_pkg::UEPSF_HS_ACK, "out ack");
		tok(E_IN, 2'h0, uepsf_pkg::UEPSF_HS_NONE, "in sends data");
		u_host.send(E_OUT_ACK, 2'h0, 1'b0);
		rd(`UEPSF_OFF_RX_STATUS, 8'h00, "rx toggle flips");
		u_host.send(E_SETUP, 2'h3, 1'b0);
		rd(`UEPSF_OFF_SELECTOR, 8'h00, "selector kept");
		chk({31'h0000_0000, rx_fifo_lock[3]}, 32'h0000_0000, "no lock on ep3");
		$display("setup test finished");
	endtask
	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// Reset for two cycles, then the scenarios in order
	initial begin
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		t_reset();
		t_tx();
		t_setup();
		end_of_test();
	end
endmodule
